/* include/spx_params.svh */
// Constants for the page permission extend leaf
`ifndef SPX_PARAMS_SVH
`define SPX_PARAMS_SVH
`define SPX_LEAF_PERM_EXTEND 32'h0000_0006
`define SPX_DESC_ALIGN_MASK 64'h0000_0000_0000_003F
`define SPX_PAGE_OFS_MASK 64'h0000_0000_0000_0FFF
`define SPX_DESC_WORDS 8
`define SPX_WORD_BYTES 64'h0000_0000_0000_0008
`define SPX_DESC_RSVD_MASK0 64'hFFFF_FFFF_FFFF_00F8
`define SPX_FLAG_R 0
`define SPX_FLAG_W 1
`define SPX_FLAG_X 2
`define SPX_REGULAR_PAGE_TYPE 8'h01
`define SPX_CANON_MSB 47
`define SPX_REG_CTRL 4'h0
`define SPX_REG_STATUS 4'h4
`define SPX_REG_FLT_LO 4'h8
`define SPX_REG_FLT_HI 4'hC
`define SPX_CTRL_RESET 1'h1
`endif

/* include/spx_pkg.sv */
// Types shared by the permission extend leaf logic
`default_nettype none
package spx_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_DMETA, ST_DREAD, ST_TMETA, ST_LOCK, ST_RECHK, ST_WRITE} spx_state_e;
	typedef enum logic [1:0] {FLT_NONE, FLT_GP, FLT_PF} spx_fault_e;
endpackage
`default_nettype wire

/* hw/spx_perm_extend.sv */
// Execution logic of the page permission extend leaf
// Functional notes
// RQ1: Leaf 06H only ever adds page rights
// RQ2: Outside enclave gives general protection, code zero
// RQ3: Software loads descriptor and target pointers first
// RQ4: Descriptor pointer must be 64-byte aligned
// RQ5: Target pointer must be 4-kilobyte aligned
// RQ6: Both pointers inside enclave linear range
// RQ7: Untranslated address gives page fault there
// RQ8: Descriptor page metadata fully checked, else page fault
// RQ9: Copy descriptor; nonzero reserved gives protection fault
// RQ10: Target metadata checked before concurrency step
// RQ11: Target exclusive against modify leaves; conflict faults
// RQ12: Target metadata rechecked after gaining page
// RQ13: Write without read gives protection fault
// RQ14: New permissions are old OR requested
// RQ15: Segment limit or non-canonical gives protection fault
// RQ16: Operand locked by other thread faults
// RQ17: Flags untouched; faults leave permissions unchanged
//
// Local design decisions: the register addresses and the strobed register port.
`include "spx_params.svh"
`default_nettype none
module spx_perm_extend #(
	parameter int ADDR_W = 64
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Leaf issue from the core
	input wire logic leaf_valid,
	input wire logic [31:0] leaf_sel,
	input wire logic [ADDR_W-1:0] base_operand_reg,
	input wire logic [ADDR_W-1:0] count_operand_reg,
	input wire logic in_enclave,
	input wire logic long_mode,
	input wire logic [31:0] ds_limit,
	input wire logic operand_locked,
	input wire logic [ADDR_W-1:0] range_base,
	input wire logic [ADDR_W-1:0] range_limit,
	input wire logic [ADDR_W-1:0] active_enclave_control,
	// Leaf result
	output logic busy,
	output logic done,
	output logic general_protection_fault,
	output logic page_fault_exception,
	output logic [ADDR_W-1:0] fault_addr,
	// Page metadata map port
	output logic meta_req,
	output logic [ADDR_W-1:0] meta_addr,
	input wire logic meta_rdy,
	input wire logic meta_in_ppc,
	input wire logic meta_valid,
	input wire logic [2:0] meta_rwx,
	input wire logic meta_pending,
	input wire logic changed_pending_bit,
	input wire logic page_bit_a,
	input wire logic [7:0] meta_type,
	input wire logic [ADDR_W-1:0] owner_enclave_ref,
	input wire logic [ADDR_W-1:0] recorded_linear_addr,
	output logic meta_wr,
	output logic [2:0] meta_wr_rwx,
	// Descriptor read port
	output logic mem_req,
	output logic [ADDR_W-1:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [63:0] mem_rdata,
	// Page exclusivity lock
	output logic lock_req,
	output logic lock_excl,
	input wire logic lock_ack,
	input wire logic lock_conflict,
	output logic lock_release,
	// Register port
	input wire logic [3:0] rb_addr,
	input wire logic [31:0] rb_wdata,
	input wire logic rb_we,
	input wire logic rb_re,
	output logic [31:0] rb_rdata
);
	// ********************
	// Helpers
	// ********************
	// Checks common to all metadata lookups; page_bit_a is not rechecked
	function automatic logic meta_ok(input logic chk_page_bit_a);
		meta_ok = meta_in_ppc && meta_valid && !meta_pending && !changed_pending_bit &&
			!(chk_page_bit_a && page_bit_a) && (meta_type == `SPX_REGULAR_PAGE_TYPE) &&
			(owner_enclave_ref == active_enclave_control);
	endfunction
	// Canonical in long mode, segment limit otherwise
	function automatic logic addr_bad(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] last);
		logic [ADDR_W-1:0] e;
		e = a + last;
		if (long_mode) begin
			addr_bad = !((&a[ADDR_W-1:`SPX_CANON_MSB]) || !(|a[ADDR_W-1:`SPX_CANON_MSB]));
		end else begin
			addr_bad = (e[31:0] > ds_limit) || (e[31:0] < a[31:0]);
		end
	endfunction
	function automatic logic in_range(input logic [ADDR_W-1:0] a);
		in_range = (a >= range_base) && (a <= range_limit);
	endfunction

	// ********************
	// Leaf sequencer
	// ********************
	spx_pkg::spx_state_e state_q, state_d;
	logic [ADDR_W-1:0] desc_q, desc_d, tgt_q, tgt_d, maddr_q, maddr_d, faddr_q, faddr_d;
	logic [ADDR_W-1:0] maddr_base;
	logic [63:0] scratch_q [`SPX_DESC_WORDS];
	logic [63:0] scratch_d [`SPX_DESC_WORDS];
	logic [2:0] word_q, word_d, old_q, old_d, new_q, new_d;
	logic done_q, done_d, gp_q, gp_d, pf_q, pf_d;
	logic start, rsvd_bad, desc_meta_ok;
	logic [2:0] req_rwx;
	logic ctrl_en_q, ctrl_en_d;
	spx_pkg::spx_fault_e last_q, last_d;
	logic [15:0] count_q, count_d;
	logic [31:0] rdata_q, rdata_d;

	// Only leaf 06H from the core starts work, and only while enabled
	assign start = (state_q == spx_pkg::ST_IDLE) && leaf_valid && ctrl_en_q &&
		(leaf_sel == `SPX_LEAF_PERM_EXTEND); // RQ1
	// Reserved descriptor content, scanned over the whole copy
	always_comb begin
		rsvd_bad = |(scratch_q[0] & `SPX_DESC_RSVD_MASK0); // RQ9
		for (int i = 1; i < `SPX_DESC_WORDS; i++) begin
			rsvd_bad = rsvd_bad | (|scratch_q[i]); // RQ9
		end
	end
	assign req_rwx = scratch_q[0][`SPX_FLAG_X:`SPX_FLAG_R];
	assign desc_meta_ok = meta_ok(1'b1) && meta_rwx[`SPX_FLAG_R] &&
		(recorded_linear_addr == (desc_q & ~`SPX_PAGE_OFS_MASK)); // RQ8
	assign maddr_base = desc_q & ~`SPX_PAGE_OFS_MASK;

	// Next state; every fault returns to idle before any metadata write
	always_comb begin
		state_d = state_q;
		desc_d = desc_q;
		tgt_d = tgt_q;
		maddr_d = maddr_q;
		faddr_d = faddr_q;
		scratch_d = scratch_q;
		word_d = word_q;
		old_d = old_q;
		new_d = new_q;
		done_d = 1'b0;
		gp_d = 1'b0;
		pf_d = 1'b0;
		unique case (state_q)
			spx_pkg::ST_IDLE: begin
				if (start) begin
					desc_d = base_operand_reg; // RQ3
					tgt_d = count_operand_reg; // RQ3
					faddr_d = '0;
					if (!in_enclave) begin
						gp_d = 1'b1; // RQ2
					end else if (addr_bad(base_operand_reg, `SPX_DESC_ALIGN_MASK) ||
						addr_bad(count_operand_reg, `SPX_PAGE_OFS_MASK)) begin
						gp_d = 1'b1; // RQ15
					end else if (operand_locked) begin
						gp_d = 1'b1; // RQ16
					end else if (|(base_operand_reg & `SPX_DESC_ALIGN_MASK)) begin
						gp_d = 1'b1; // RQ4
					end else if (|(count_operand_reg & `SPX_PAGE_OFS_MASK)) begin
						gp_d = 1'b1; // RQ5
					end else if (!in_range(base_operand_reg) || !in_range(count_operand_reg)) begin
						gp_d = 1'b1; // RQ6
					end else begin
						maddr_d = base_operand_reg;
						state_d = spx_pkg::ST_DMETA;
					end
				end
			end
			spx_pkg::ST_DMETA: begin
				if (meta_rdy) begin
					if (!desc_meta_ok) begin
						pf_d = 1'b1; // RQ7 RQ8
						faddr_d = desc_q;
						state_d = spx_pkg::ST_IDLE;
					end else begin
						word_d = '0;
						maddr_d = desc_q;
						state_d = spx_pkg::ST_DREAD;
					end
				end
			end
			spx_pkg::ST_DREAD: begin
				if (mem_ack) begin
					scratch_d[word_q] = mem_rdata; // RQ9
					word_d = word_q + 3'h1;
					maddr_d = maddr_q + `SPX_WORD_BYTES;
					if (word_q == 3'(`SPX_DESC_WORDS - 1)) begin
						maddr_d = tgt_q;
						state_d = spx_pkg::ST_TMETA;
					end
				end
			end
			spx_pkg::ST_TMETA: begin
				if (rsvd_bad) begin
					gp_d = 1'b1; // RQ9
					state_d = spx_pkg::ST_IDLE;
				end else if (meta_rdy) begin
					if (!meta_ok(1'b1)) begin
						pf_d = 1'b1; // RQ7 RQ10
						faddr_d = tgt_q;
						state_d = spx_pkg::ST_IDLE;
					end else begin
						state_d = spx_pkg::ST_LOCK;
					end
				end
			end
			spx_pkg::ST_LOCK: begin
				if (lock_ack) begin
					if (lock_conflict) begin
						gp_d = 1'b1; // RQ11
						state_d = spx_pkg::ST_IDLE;
					end else begin
						state_d = spx_pkg::ST_RECHK;
					end
				end
			end
			spx_pkg::ST_RECHK: begin
				if (meta_rdy) begin
					old_d = meta_rwx;
					new_d = meta_rwx | req_rwx; // RQ14
					if (!meta_ok(1'b0) || (recorded_linear_addr != tgt_q)) begin
						pf_d = 1'b1; // RQ12
						faddr_d = tgt_q;
						state_d = spx_pkg::ST_IDLE;
					end else if (!meta_rwx[`SPX_FLAG_R] && !req_rwx[`SPX_FLAG_R] &&
						req_rwx[`SPX_FLAG_W]) begin
						gp_d = 1'b1; // RQ13
						state_d = spx_pkg::ST_IDLE;
					end else begin
						state_d = spx_pkg::ST_WRITE;
					end
				end
			end
			spx_pkg::ST_WRITE: begin
				done_d = 1'b1;
				state_d = spx_pkg::ST_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= spx_pkg::ST_IDLE;
			desc_q <= '0;
			tgt_q <= '0;
			maddr_q <= '0;
			faddr_q <= '0;
			for (int i = 0; i < `SPX_DESC_WORDS; i++) begin
				scratch_q[i] <= '0;
			end
			word_q <= '0;
			old_q <= '0;
			new_q <= '0;
			done_q <= 1'b0;
			gp_q <= 1'b0;
			pf_q <= 1'b0;
		end else begin
			state_q <= state_d;
			desc_q <= desc_d;
			tgt_q <= tgt_d;
			maddr_q <= maddr_d;
			faddr_q <= faddr_d;
			scratch_q <= scratch_d;
			word_q <= word_d;
			old_q <= old_d;
			new_q <= new_d;
			done_q <= done_d;
			gp_q <= gp_d;
			pf_q <= pf_d;
		end
	end

	// Handshakes; metadata write only in the final step, never after a fault
	assign meta_req = (state_q == spx_pkg::ST_DMETA) || (state_q == spx_pkg::ST_TMETA && !rsvd_bad) ||
		(state_q == spx_pkg::ST_RECHK);
	assign meta_addr = (state_q == spx_pkg::ST_DMETA) ? maddr_base : maddr_q;
	assign mem_req = (state_q == spx_pkg::ST_DREAD);
	assign mem_addr = maddr_q;
	assign lock_req = (state_q == spx_pkg::ST_LOCK);
	assign lock_excl = 1'b1; // RQ11
	assign lock_release = (state_q == spx_pkg::ST_WRITE) ||
		(state_q == spx_pkg::ST_RECHK && meta_rdy && state_d == spx_pkg::ST_IDLE);
	assign meta_wr = (state_q == spx_pkg::ST_WRITE); // RQ17
	assign meta_wr_rwx = new_q; // RQ14
	assign busy = (state_q != spx_pkg::ST_IDLE);
	assign done = done_q;
	assign general_protection_fault = gp_q;
	assign page_fault_exception = pf_q;
	assign fault_addr = faddr_q;

	// ********************
	// Register port
	// ********************
	// Status shows live state; the count helps software see forward progress
	always_comb begin
		ctrl_en_d = ctrl_en_q;
		last_d = last_q;
		count_d = count_q;
		rdata_d = '0;
		if (rb_we && rb_addr == `SPX_REG_CTRL) begin
			ctrl_en_d = rb_wdata[0];
		end
		if (gp_q) begin
			last_d = spx_pkg::FLT_GP;
		end else if (pf_q) begin
			last_d = spx_pkg::FLT_PF;
		end else if (done_q) begin
			last_d = spx_pkg::FLT_NONE;
			count_d = count_q + 16'h0001;
		end
		if (rb_re) begin
			unique case (rb_addr)
				`SPX_REG_CTRL: rdata_d = {31'h0, ctrl_en_q};
				`SPX_REG_STATUS: rdata_d = {count_q, 13'h0, last_q, busy};
				`SPX_REG_FLT_LO: rdata_d = faddr_q[31:0];
				`SPX_REG_FLT_HI: rdata_d = faddr_q[63:32];
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_en_q <= `SPX_CTRL_RESET;
			last_q <= spx_pkg::FLT_NONE;
			count_q <= '0;
			rdata_q <= '0;
		end else begin
			ctrl_en_q <= ctrl_en_d;
			last_q <= last_d;
			count_q <= count_d;
			rdata_q <= rdata_d;
		end
	end
	assign rb_rdata = rdata_q;

	// ********************
	// Assertions
	// ********************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence start_s;
		state_q == spx_pkg::ST_IDLE && leaf_valid && ctrl_en_q && leaf_sel == `SPX_LEAF_PERM_EXTEND;
	endsequence
	sequence rechk_s;
		state_q == spx_pkg::ST_RECHK && meta_rdy;
	endsequence
	leaf_select_a: assert property (leaf_valid && leaf_sel != `SPX_LEAF_PERM_EXTEND &&
		state_q == spx_pkg::ST_IDLE |=> state_q == spx_pkg::ST_IDLE && !general_protection_fault)
		else $error("foreign leaf started"); // RQ1
	outside_gp_a: assert property (start_s and !in_enclave |=> general_protection_fault &&
		!busy) else $error("no fault outside enclave"); // RQ2
	desc_align_a: assert property (start_s and in_enclave && base_operand_reg[5:0] != 6'h00 |=>
		general_protection_fault) else $error("misaligned descriptor accepted"); // RQ4
	tgt_align_a: assert property (start_s and in_enclave && count_operand_reg[11:0] != 12'h000 |=>
		general_protection_fault) else $error("misaligned target accepted"); // RQ5
	desc_pf_a: assert property (state_q == spx_pkg::ST_DMETA && meta_rdy && !meta_in_ppc |=>
		page_fault_exception && fault_addr == desc_q) else $error("descriptor fault wrong"); // RQ7
	rsvd_gp_a: assert property (state_q == spx_pkg::ST_TMETA && rsvd_bad |=> general_protection_fault)
		else $error("reserved bits ignored"); // RQ9
	conflict_gp_a: assert property (state_q == spx_pkg::ST_LOCK && lock_ack && lock_conflict |=>
		general_protection_fault ##1 !meta_wr) else $error("conflict not faulted"); // RQ11
	wnor_gp_a: assert property (rechk_s ##0 meta_ok(1'b0) && recorded_linear_addr == tgt_q &&
		!meta_rwx[0] && !req_rwx[0] && req_rwx[1] |=> general_protection_fault && !meta_wr)
		else $error("write without read allowed"); // RQ13
	or_update_a: assert property (meta_wr |-> (meta_wr_rwx & old_q) == old_q &&
		meta_wr_rwx == (old_q | req_rwx) ##1 done) else $error("permissions not widened"); // RQ14
	no_wr_fault_a: assert property (general_protection_fault || page_fault_exception |->
		!meta_wr && !done) else $error("write beside fault"); // RQ17
endmodule
`default_nettype wire

/* test/spx_page_model.sv */
// Far-side model: page metadata map, descriptor memory and page lock
`include "spx_params.svh"
`default_nettype none
module spx_page_model #(
	parameter logic [63:0] ENC = 64'h5000
) (
	// Clock
	input wire logic ref_clk,
	// Metadata map
	input wire logic meta_req,
	input wire logic [63:0] meta_addr,
	output logic meta_rdy,
	output logic meta_in_ppc,
	output logic meta_valid,
	output logic [2:0] meta_rwx,
	output logic meta_pending,
	output logic changed_pending_bit,
	output logic page_bit_a,
	output logic [7:0] meta_type,
	output logic [63:0] owner_enclave_ref,
	output logic [63:0] recorded_linear_addr,
	input wire logic meta_wr,
	input wire logic [2:0] meta_wr_rwx,
	// Descriptor memory
	input wire logic mem_req,
	input wire logic [63:0] mem_addr,
	output logic mem_ack,
	output logic [63:0] mem_rdata,
	// Page lock
	input wire logic lock_req,
	input wire logic lock_excl,
	input wire logic lock_release,
	output logic lock_ack,
	output logic lock_conflict
);
	timeunit 1ns;
	timeprecision 1ps;
	// Knobs set by the bench between leaves; each fault flag breaks a single check
	int lat = 0;
	logic [63:0] dptr = 64'h10_0040;
	logic [63:0] w0 = 64'h0;
	logic [2:0] t_rwx = 3'h1;
	logic d_bad = 0, t_nppc = 0, t_blk = 0, t_mis = 0, rsv = 0, conf = 0;
	int mc = 0, wc = 0, lc = 0, rc = 0;
	logic dsel;
	// Answers come after lat waiting cycles; fields are gated so stale data never looks valid
	assign dsel = meta_addr == {dptr[63:12], 12'h000};
	assign meta_rdy = meta_req && mc >= lat;
	assign meta_in_ppc = meta_rdy && !(t_nppc && !dsel);
	assign meta_valid = meta_rdy && !(d_bad && dsel);
	assign meta_rwx = !meta_rdy ? ~t_rwx : dsel ? 3'h1 : t_rwx;
	assign meta_pending = 1'b0;
	assign changed_pending_bit = 1'b0;
	assign page_bit_a = t_blk && !dsel;
	assign meta_type = `SPX_REGULAR_PAGE_TYPE;
	assign owner_enclave_ref = ENC;
	assign recorded_linear_addr = dsel ? meta_addr : meta_addr + (t_mis ? 64'h1000 : 64'h0);
	assign mem_ack = mem_req && wc >= lat;
	assign mem_rdata = !mem_ack ? ~w0 : (mem_addr == dptr) ? w0 : {63'h0, rsv};
	// A shared lock request is never granted, so a lost exclusive flag shows up as a timeout
	assign lock_ack = lock_req && lock_excl && lc >= lat;
	assign lock_conflict = lock_ack && conf;
	// Wait counters and the permission store
	always @(posedge ref_clk) begin
		mc <= (meta_req && !meta_rdy) ? mc + 1 : 0;
		wc <= (mem_req && !mem_ack) ? wc + 1 : 0;
		lc <= (lock_req && !lock_ack) ? lc + 1 : 0;
		if (meta_wr === 1'b1)
			t_rwx <= meta_wr_rwx;
		if (lock_release === 1'b1)
			rc <= rc + 1;
	end
endmodule
`default_nettype wire

/* test/tb_secure_page_permission_extend.sv */
// Self-checking bench for the permission extend leaf
`include "spx_params.svh"
`default_nettype none
module tb_secure_page_permission_extend;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] ENC = 64'h5000, D = 64'h10_0040, T = 64'h12_3000;
	localparam logic [31:0] L = `SPX_LEAF_PERM_EXTEND;
	logic ref_clk = 0, rst = 1, leaf_valid = 0, in_enclave = 1, long_mode = 1, operand_locked = 0, rb_we = 0, rb_re = 0;
	logic busy, done, general_protection_fault, page_fault_exception, meta_req, meta_rdy, meta_in_ppc, meta_valid;
	logic meta_pending, changed_pending_bit, page_bit_a, meta_wr, mem_req, mem_ack, lock_req, lock_excl, lock_ack;
	logic lock_conflict, lock_release;
	logic [2:0] meta_rwx, meta_wr_rwx;
	logic [7:0] meta_type;
	logic [3:0] rb_addr = 0;
	logic [31:0] leaf_sel = 0, ds_limit = 32'hFFFF_FFFF, rb_wdata = 0, rb_rdata, r;
	logic [63:0] base_operand_reg = 0, count_operand_reg = 0, range_base = 64'h10_0000, range_limit = 64'h1F_FFFF;
	logic [63:0] active_enclave_control = ENC, fault_addr, meta_addr, owner_enclave_ref, recorded_linear_addr;
	logic [63:0] mem_addr, mem_rdata;
	int fail_count = 0, n_checks = 0;
	spx_perm_extend uut (
		.ref_clk(ref_clk), .rst(rst), .leaf_valid(leaf_valid), .leaf_sel(leaf_sel),
		.base_operand_reg(base_operand_reg), .count_operand_reg(count_operand_reg),
		.in_enclave(in_enclave), .long_mode(long_mode), .ds_limit(ds_limit),
		.operand_locked(operand_locked), .range_base(range_base), .range_limit(range_limit),
		.active_enclave_control(active_enclave_control), .busy(busy), .done(done),
		.general_protection_fault(general_protection_fault),
		.page_fault_exception(page_fault_exception), .fault_addr(fault_addr),
		.meta_req(meta_req), .meta_addr(meta_addr), .meta_rdy(meta_rdy), .meta_in_ppc(meta_in_ppc),
		.meta_valid(meta_valid), .meta_rwx(meta_rwx), .meta_pending(meta_pending),
		.changed_pending_bit(changed_pending_bit), .page_bit_a(page_bit_a), .meta_type(meta_type),
		.owner_enclave_ref(owner_enclave_ref), .recorded_linear_addr(recorded_linear_addr),
		.meta_wr(meta_wr), .meta_wr_rwx(meta_wr_rwx), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .lock_req(lock_req), .lock_excl(lock_excl),
		.lock_ack(lock_ack), .lock_conflict(lock_conflict), .lock_release(lock_release),
		.rb_addr(rb_addr), .rb_wdata(rb_wdata), .rb_we(rb_we), .rb_re(rb_re), .rb_rdata(rb_rdata)
	);
	spx_page_model #(.ENC(ENC)) pm (
		.ref_clk(ref_clk), .meta_req(meta_req), .meta_addr(meta_addr), .meta_rdy(meta_rdy),
		.meta_in_ppc(meta_in_ppc), .meta_valid(meta_valid), .meta_rwx(meta_rwx),
		.meta_pending(meta_pending), .changed_pending_bit(changed_pending_bit),
		.page_bit_a(page_bit_a), .meta_type(meta_type), .owner_enclave_ref(owner_enclave_ref),
		.recorded_linear_addr(recorded_linear_addr), .meta_wr(meta_wr), .meta_wr_rwx(meta_wr_rwx),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.lock_req(lock_req), .lock_excl(lock_excl), .lock_release(lock_release),
		.lock_ack(lock_ack), .lock_conflict(lock_conflict)
	);
	always #2 ref_clk = ~ref_clk;
	// ***************
	// Shared tasks
	// ***************
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Issue one leaf and judge its one result pulse; code 3 means no pulse may come
	task automatic run(input logic [31:0] sel, input logic [63:0] b, input logic [63:0] c, input logic [1:0] code,
			input logic [63:0] fa);
		logic [1:0] got;
		got = 2'h3;
		@(posedge ref_clk);
		leaf_sel <= sel;
		base_operand_reg <= b;
		count_operand_reg <= c;
		leaf_valid <= 1'b1;
		@(posedge ref_clk);
		leaf_valid <= 1'b0;
		// Look first in the cycle after the taking edge, where an early fault pulse stands
		for (int i = 0; i < 100 && got == 2'h3; i++) begin
			#1;
			if (done === 1'b1)
				got = 2'h0;
			else if (general_protection_fault === 1'b1)
				got = 2'h1;
			else if (page_fault_exception === 1'b1)
				got = 2'h2;
			@(posedge ref_clk);
		end
		if (got == 2'h3 && code != 2'h3) begin
			fail_count++;
			close_out();
		end else begin
			check({62'h0, got}, {62'h0, code});
			if (code == 2'h1 || code == 2'h2)
				check(fault_addr, fa);
		end
	endtask
	// Register port: read data is taken in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		rb_addr <= a;
		rb_re <= 1'b1;
		@(posedge ref_clk);
		rb_re <= 1'b0;
		#1 r = rb_rdata;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		rb_addr <= a;
		rb_wdata <= d;
		rb_we <= 1'b1;
		@(posedge ref_clk);
		rb_we <= 1'b0;
	endtask
	// ***************
	// Scenarios
	// ***************
	// Extensions with prompt and slow answers; the free field must not count as reserved
	task automatic grant_ok();
		pm.t_rwx = 3'h1;
		pm.w0 = 64'hAB04;
		run(L, D, T, 2'h0, 64'h0);
		check({61'h0, pm.t_rwx}, 64'h5);
		pm.lat = 3;
		pm.w0 = 64'h2;
		run(L, D, T, 2'h0, 64'h0);
		check({61'h0, pm.t_rwx}, 64'h7);
		pm.w0 = 64'h1;
		run(L, D, T, 2'h0, 64'h0);
		check({61'h0, pm.t_rwx}, 64'h7);
		pm.lat = 0;
		run(32'h7, D, T, 2'h3, 64'h0);
		check({32'h0, pm.rc}, 64'h3);
	endtask
	// Faults decided before any lookup, at range and limit boundaries
	task automatic early_gp();
		pm.t_rwx = 3'h1;
		in_enclave <= 1'b0;
		run(L, D, T, 2'h1, 64'h0);
		in_enclave <= 1'b1;
		run(L, D + 64'h8, T, 2'h1, 64'h0);
		run(L, D, T + 64'h10, 2'h1, 64'h0);
		run(L, 64'h20_0040, T, 2'h1, 64'h0);
		run(L, D, 64'h20_0000, 2'h1, 64'h0);
		operand_locked <= 1'b1;
		run(L, D, T, 2'h1, 64'h0);
		operand_locked <= 1'b0;
		run(L, 64'h8000_0000_0010_0040, T, 2'h1, 64'h0);
		long_mode <= 1'b0;
		ds_limit <= 32'h0012_2FFF;
		run(L, D, T, 2'h1, 64'h0);
		long_mode <= 1'b1;
		ds_limit <= 32'hFFFF_FFFF;
		check({61'h0, pm.t_rwx}, 64'h1);
	endtask
	// Faults from metadata, descriptor content, lock and recheck
	task automatic late_faults();
		pm.d_bad = 1;
		run(L, D, T, 2'h2, D);
		pm.d_bad = 0;
		pm.t_nppc = 1;
		run(L, D, T, 2'h2, T);
		pm.t_nppc = 0;
		pm.rsv = 1;
		run(L, D, T, 2'h1, 64'h0);
		pm.rsv = 0;
		pm.t_blk = 1;
		run(L, D, T, 2'h2, T);
		pm.t_blk = 0;
		pm.conf = 1;
		run(L, D, T, 2'h1, 64'h0);
		pm.conf = 0;
		pm.t_mis = 1;
		run(L, D, T, 2'h2, T);
		pm.t_mis = 0;
		pm.t_rwx = 3'h0;
		pm.w0 = 64'h2;
		run(L, D, T, 2'h1, 64'h0);
		check({61'h0, pm.t_rwx}, 64'h0);
		check({32'h0, pm.rc}, 64'h5);
	endtask
	// Status after the last fault, unmapped read, and the enable bit
	task automatic regs();
		rd(4'h4);
		check({32'h0, r}, 64'h0003_0002);
		rd(4'h8);
		check({32'h0, r}, 64'h0);
		rd(4'hC);
		check({32'h0, r}, 64'h0);
		rd(4'h2);
		check({32'h0, r}, 64'h0);
		rd(4'h0);
		check({32'h0, r}, 64'h1);
		wr(4'h0, 32'h0);
		run(L, D, T, 2'h3, 64'h0);
		wr(4'h0, 32'h1);
		pm.w0 = 64'h1;
		run(L, D, T, 2'h0, 64'h0);
	endtask
	// Main sequence: reset for 12 cycles, then every scenario in turn
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		grant_ok();
		early_gp();
		late_faults();
		regs();
		close_out();
	end
endmodule
`default_nettype wire
